// file: logic/node_config_registers.sv
// Node configuration register bank with routing lookup and PLL write reset
`include "node_cfg_defs.svh"
// What this block does
// - Switch lock bit 31 set refuses writes to switch control registers; resets zero.
// - Bit 8 set blocks writes to the PLL control register; resets zero.
// - Bit 0 selects header length: zero two bytes, one one byte.
// - Node identifier holds a writable 16-bit number, reset zero, upper bits zero.
// - A PLL settings write while the reset sequencer is in RS_IDLE resets the tile unless suppressed.
// - Written PLL bit 31 set skips the reset.
// - PLL bit 30 set means no wait for re-lock; only for gradual changes.
// - PLL bit 29 set bypasses the PLL.
// - PLL bit 28 set forces boot from JTAG.
// - Output divider field holds divider minus one, range one to eight.
// - Feedback multiplier field holds ratio minus one, range one to 8192.
// - Input divider field holds divider minus one, range one to 128.
// - Writable 16-bit switch clock ratio, reset zero.
// - Writable 16-bit reference clock ratio, reset three.
// - User code reads OTP value high and fixed ID code in low 18 bits.
// - Packets route by most significant bit where destination differs from node ID.
// - Low directions: eight nibbles for positions 7..0, nibble k at 4k+3:4k.
// - High directions: positions 15..8, position 8 lowest nibble, reset zero.
// - Debug source flags which core raised the last global debug event.
module node_config_registers #(
    parameter int              RESET_CYCLES = 4,
    parameter logic [31:0]     SCAN_ID      = `SCAN_ID_VALUE,  // Arbitrary value
    parameter logic [17:0]     USER_FIX     = `USER_FIX_VALUE  // Arbitrary value
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire node_cfg_pkg::cfg_req_t  i_req,
    output node_cfg_pkg::cfg_rsp_t       o_rsp,
    input  wire logic [13:0]             i_otp_user,
    input  wire logic                    i_dbg_event,
    input  wire logic [1:0]              i_dbg_cores,
    input  wire logic                    i_pll_locked,
    input  wire logic [15:0]             i_dest_id,
    output logic                         o_header_one_byte,
    output logic                         o_ctl_locked,
    output logic [15:0]                  o_node_id,
    output node_cfg_pkg::pll_cfg_t       o_pll,
    output logic [15:0]                  o_switch_div,
    output logic [15:0]                  o_ref_div,
    output logic                         o_tile_reset,
    output logic                         o_route_local,
    output logic [3:0]                   o_route_dir
);
    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_HOLD = 3'b010,
        RS_LOCK = 3'b100
    } rst_state_t;

    logic        ctl_lock;
    logic        pll_lock;
    logic        header_one;
    logic [15:0] node_id;
    logic [31:0] pll_reg;
    logic [15:0] switch_div;
    logic [15:0] ref_div;
    logic [31:0] dirs_low;
    logic [31:0] dirs_high;
    logic [1:0]  resv_a;
    logic [1:0]  resv_b;
    logic [1:0]  debug_src;
    logic        debug_resv;
    rst_state_t  rst_state;
    logic [7:0]  rst_count;
    logic [31:0] next_rdata;
    logic        wr;
    logic        wr_ctl;
    logic        wr_pll;
    logic        route_local;
    logic [3:0]  route_dir;

    assign wr     = i_req.valid && i_req.write;
    assign wr_ctl = wr && !ctl_lock;
    assign wr_pll = wr && !pll_lock && (i_req.addr == `ADDR_PLL_SETTINGS);

    // Lock bits are writable only while the control lock is clear, so it sticks once set
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctl_lock   <= 1'b0;
            pll_lock   <= 1'b0;
            header_one <= 1'b0;
        end else if (wr_ctl && i_req.addr == `ADDR_SWITCH_LOCK) begin
            ctl_lock   <= i_req.wdata[`BIT_CTL_LOCK];
            pll_lock   <= i_req.wdata[`BIT_PLL_LOCK];
            header_one <= i_req.wdata[`BIT_HEADER_ONE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            node_id <= `RST_NODE_ID;
        end else if (wr_ctl && i_req.addr == `ADDR_NODE_ID) begin
            node_id <= i_req.wdata[15:0];
        end
    end

    // Fields keep their minus-one encoding; reserved bits are masked off
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pll_reg <= `RST_PLL;
        end else if (wr_pll) begin
            pll_reg <= i_req.wdata & `PLL_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            switch_div <= `RST_SWITCH_DIV;
            ref_div    <= `RST_REF_DIV;
        end else if (wr_ctl && i_req.addr == `ADDR_SWITCH_DIV) begin
            switch_div <= i_req.wdata[15:0];
        end else if (wr_ctl && i_req.addr == `ADDR_REF_DIV) begin
            ref_div <= i_req.wdata[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            dirs_low  <= `RST_DIRS;
            dirs_high <= `RST_DIRS;
            resv_a    <= `RST_RESV;
            resv_b    <= `RST_RESV;
        end else if (wr_ctl && i_req.addr == `ADDR_DIR_LOW) begin
            dirs_low <= i_req.wdata;
        end else if (wr_ctl && i_req.addr == `ADDR_DIR_HIGH) begin
            dirs_high <= i_req.wdata;
        end else if (wr_ctl && i_req.addr == `ADDR_RESV_A) begin
            resv_a <= i_req.wdata[1:0];
        end else if (wr_ctl && i_req.addr == `ADDR_RESV_B) begin
            resv_b <= i_req.wdata[1:0];
        end
    end

    // A debug event wins over a software write in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            debug_src  <= `RST_DEBUG;
            debug_resv <= 1'b0;
        end else if (i_dbg_event) begin
            debug_src <= i_dbg_cores;
        end else if (wr_ctl && i_req.addr == `ADDR_DEBUG_SRC) begin
            debug_src  <= i_req.wdata[1:0];
            debug_resv <= i_req.wdata[4];
        end
    end

    // Tile reset sequencer: hold reset, then wait for PLL lock unless told not to
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rst_state    <= RS_IDLE;
            rst_count    <= 8'h00;
            o_tile_reset <= 1'b0;
        end else begin
            case (rst_state)
                RS_IDLE: begin
                    if (wr_pll && !i_req.wdata[`BIT_PLL_NO_RESET]) begin
                        rst_state    <= RS_HOLD;
                        rst_count    <= 8'(RESET_CYCLES - 1);
                        o_tile_reset <= 1'b1;
                    end
                end
                RS_HOLD: begin
                    if (rst_count != 8'h00) begin
                        rst_count <= rst_count - 8'h01;
                    end else if (pll_reg[`BIT_PLL_NO_WAIT] || i_pll_locked) begin
                        rst_state    <= RS_IDLE;
                        o_tile_reset <= 1'b0;
                    end else begin
                        rst_state <= RS_LOCK;
                    end
                end
                RS_LOCK: begin
                    if (i_pll_locked) begin
                        rst_state    <= RS_IDLE;
                        o_tile_reset <= 1'b0;
                    end
                end
                default: begin
                    rst_state    <= RS_IDLE;
                    o_tile_reset <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_req.addr == `ADDR_SWITCH_LOCK) begin
            next_rdata[`BIT_CTL_LOCK]   = ctl_lock;
            next_rdata[`BIT_PLL_LOCK]   = pll_lock;
            next_rdata[`BIT_HEADER_ONE] = header_one;
        end else if (i_req.addr == `ADDR_NODE_ID) begin
            next_rdata[15:0] = node_id;
        end else if (i_req.addr == `ADDR_PLL_SETTINGS) begin
            next_rdata = pll_reg;
        end else if (i_req.addr == `ADDR_SWITCH_DIV) begin
            next_rdata[15:0] = switch_div;
        end else if (i_req.addr == `ADDR_REF_DIV) begin
            next_rdata[15:0] = ref_div;
        end else if (i_req.addr == `ADDR_SCAN_ID) begin
            next_rdata = SCAN_ID;
        end else if (i_req.addr == `ADDR_USER_CODE) begin
            next_rdata = {i_otp_user, USER_FIX};
        end else if (i_req.addr == `ADDR_DIR_LOW) begin
            next_rdata = dirs_low;
        end else if (i_req.addr == `ADDR_DIR_HIGH) begin
            next_rdata = dirs_high;
        end else if (i_req.addr == `ADDR_RESV_A) begin
            next_rdata[1:0] = resv_a;
        end else if (i_req.addr == `ADDR_RESV_B) begin
            next_rdata[1:0] = resv_b;
        end else if (i_req.addr == `ADDR_DEBUG_SRC) begin
            next_rdata[4]   = debug_resv;
            next_rdata[1:0] = debug_src;
        end
    end

    // Every access is answered one cycle later; reads see stored values even when locked
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rsp <= '0;
        end else begin
            o_rsp.valid <= i_req.valid;
            o_rsp.rdata <= (i_req.valid && !i_req.write) ? next_rdata : 32'h0000_0000;
        end
    end

    route_lookup #(
        .ID_W (16)
    ) u_route (
        .i_node_id (node_id),
        .i_dest_id (i_dest_id),
        .i_dirs    ({dirs_high, dirs_low}),
        .o_local   (route_local),
        .o_dir     (route_dir)
    );

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_route_local     <= 1'b1;
            o_route_dir       <= 4'h0;
            o_header_one_byte <= 1'b0;
            o_ctl_locked      <= 1'b0;
            o_node_id         <= 16'h0000;
            o_pll             <= '0;
            o_switch_div      <= `RST_SWITCH_DIV;
            o_ref_div         <= `RST_REF_DIV;
        end else begin
            o_route_local     <= route_local;
            o_route_dir       <= route_dir;
            o_header_one_byte <= header_one;
            o_ctl_locked      <= ctl_lock;
            o_node_id         <= node_id;
            o_pll.out_div     <= pll_reg[`PLL_OUT_DIV_HI:`PLL_OUT_DIV_LO];
            o_pll.fb_mul      <= pll_reg[`PLL_FB_MUL_HI:`PLL_FB_MUL_LO];
            o_pll.in_div      <= pll_reg[`PLL_IN_DIV_HI:`PLL_IN_DIV_LO];
            o_pll.bypass      <= pll_reg[`BIT_PLL_BYPASS];
            o_pll.jtag_boot   <= pll_reg[`BIT_PLL_JTAG_BOOT];
            o_pll.no_wait     <= pll_reg[`BIT_PLL_NO_WAIT];
            o_switch_div      <= switch_div;
            o_ref_div         <= ref_div;
        end
    end

    sequence pll_write_s;
        wr_pll && !i_req.wdata[`BIT_PLL_NO_RESET];
    endsequence

    ctl_lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (ctl_lock && wr && i_req.addr == `ADDR_NODE_ID) |=> $stable(node_id))
        else $error("locked node id changed");
    pll_lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (pll_lock && wr && i_req.addr == `ADDR_PLL_SETTINGS) |=> $stable(pll_reg))
        else $error("locked pll register changed");
    header_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ##1 o_header_one_byte == $past(header_one))
        else $error("header mode output wrong");
    node_id_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_ctl && i_req.addr == `ADDR_NODE_ID) |=> node_id == $past(i_req.wdata[15:0]))
        else $error("node id not written");
    tile_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (pll_write_s and rst_state == RS_IDLE) |=> o_tile_reset)
        else $error("pll write did not reset tile");
    no_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_pll && i_req.wdata[`BIT_PLL_NO_RESET] && !o_tile_reset) |=> !o_tile_reset)
        else $error("suppressed reset fired");
    route_dir_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (node_id[15:1] == i_dest_id[15:1] && node_id[0] != i_dest_id[0])
        |=> o_route_dir == $past(dirs_low[3:0]))
        else $error("route direction for position zero wrong");
    debug_src_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_dbg_event |=> debug_src == $past(i_dbg_cores))
        else $error("debug source not recorded");

    // Mode bit written, then one quiet cycle so the output can follow
    sequence pll_bypass_s;
        wr_pll && i_req.wdata[`BIT_PLL_BYPASS] ##1 !wr_pll;
    endsequence
    sequence pll_jtag_s;
        wr_pll && i_req.wdata[`BIT_PLL_JTAG_BOOT] ##1 !wr_pll;
    endsequence

    pll_bypass_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pll_bypass_s |=> o_pll.bypass)
        else $error("pll bypass not applied");
    jtag_boot_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pll_jtag_s |=> o_pll.jtag_boot)
        else $error("jtag boot mode not applied");
    relock_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rst_state == RS_HOLD && rst_count == 8'h00 && !pll_reg[`BIT_PLL_NO_WAIT] && !i_pll_locked)
        |=> (rst_state == RS_LOCK && o_tile_reset))
        else $error("tile reset did not wait for lock");
    no_wait_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rst_state == RS_HOLD && rst_count == 8'h00 && pll_reg[`BIT_PLL_NO_WAIT]) |=> !o_tile_reset)
        else $error("tile reset waited although told not to");
    ctl_lock_stick_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ctl_lock |=> ctl_lock)
        else $error("control lock cleared without reset");
    locked_drop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (ctl_lock && wr && i_req.addr == `ADDR_DIR_LOW) |=> $stable(dirs_low))
        else $error("locked direction write landed");
    switch_div_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_ctl && i_req.addr == `ADDR_SWITCH_DIV) |=> switch_div == $past(i_req.wdata[15:0]))
        else $error("switch divider not written");
    ref_div_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_ctl && i_req.addr == `ADDR_REF_DIV) |=> ref_div == $past(i_req.wdata[15:0]))
        else $error("reference divider not written");
    dirs_low_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_ctl && i_req.addr == `ADDR_DIR_LOW) |=> dirs_low == $past(i_req.wdata))
        else $error("low directions not written");
    dirs_high_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (wr_ctl && i_req.addr == `ADDR_DIR_HIGH) |=> dirs_high == $past(i_req.wdata))
        else $error("high directions not written");
    route_local_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (node_id == i_dest_id) |=> o_route_local)
        else $error("local destination not flagged");
    user_code_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_req.valid && !i_req.write && i_req.addr == `ADDR_USER_CODE)
        |=> o_rsp.rdata == {$past(i_otp_user), USER_FIX})
        else $error("user code read wrong");
    rsp_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_req.valid |=> o_rsp.valid)
        else $error("access not answered");
endmodule : node_config_registers

// file: logic/node_cfg_defs.svh
// Register offsets, field positions and reset values of the node configuration bank
`ifndef NODE_CFG_DEFS_SVH
`define NODE_CFG_DEFS_SVH

`define ADDR_SWITCH_LOCK      8'h04
`define ADDR_NODE_ID          8'h05
`define ADDR_PLL_SETTINGS     8'h06
`define ADDR_SWITCH_DIV       8'h07
`define ADDR_REF_DIV          8'h08
`define ADDR_SCAN_ID          8'h09
`define ADDR_USER_CODE        8'h0A
`define ADDR_DIR_LOW          8'h0C
`define ADDR_DIR_HIGH         8'h0D
`define ADDR_RESV_A           8'h10
`define ADDR_RESV_B           8'h11
`define ADDR_DEBUG_SRC        8'h1F

`define BIT_CTL_LOCK          31
`define BIT_PLL_LOCK          8
`define BIT_HEADER_ONE        0
`define BIT_PLL_NO_RESET      31
`define BIT_PLL_NO_WAIT       30
`define BIT_PLL_BYPASS        29
`define BIT_PLL_JTAG_BOOT     28
`define PLL_OUT_DIV_HI        25
`define PLL_OUT_DIV_LO        23
`define PLL_FB_MUL_HI         20
`define PLL_FB_MUL_LO         8
`define PLL_IN_DIV_HI         6
`define PLL_IN_DIV_LO         0
`define PLL_WRITE_MASK        32'hF39F_FF7F
`define USER_FIX_HI           17
`define USER_OTP_LO           18

`define RST_SWITCH_DIV        16'h0000
`define RST_REF_DIV           16'h0003
`define RST_NODE_ID           16'h0000
`define RST_PLL               32'h0000_0000
`define RST_DIRS              32'h0000_0000
`define RST_RESV              2'h0
`define RST_DEBUG             2'h0
`define SCAN_ID_VALUE         32'h0000_0001
`define USER_FIX_VALUE        18'h00000

`endif

// file: logic/node_cfg_pkg.sv
// Types shared by the node configuration bank
package node_cfg_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic [2:0]  out_div;
        logic [12:0] fb_mul;
        logic [6:0]  in_div;
        logic        bypass;
        logic        jtag_boot;
        logic        no_wait;
    } pll_cfg_t;
endpackage : node_cfg_pkg

// file: logic/route_lookup.sv
// Routing direction lookup by most significant mismatching node identifier bit
`include "node_cfg_defs.svh"
module route_lookup #(
    parameter int ID_W = 16
) (
    input  wire logic [ID_W-1:0]   i_node_id,
    input  wire logic [ID_W-1:0]   i_dest_id,
    input  wire logic [4*ID_W-1:0] i_dirs,
    output logic                   o_local,
    output logic [3:0]             o_dir
);
    logic [ID_W-1:0] diff;
    assign diff = i_node_id ^ i_dest_id;

    always_comb begin
        o_local = 1'b1;
        o_dir   = 4'h0;
        for (int k = 0; k < ID_W; k++) begin
            if (diff[k]) begin
                o_local = 1'b0;
                o_dir   = i_dirs[4*k +: 4];
            end
        end
    end
endmodule : route_lookup

// file: verif/cfg_master.sv
// Configuration master model that issues reads and writes to the node bank
module cfg_master (
    input  wire logic                   i_clk,
    input  wire node_cfg_pkg::cfg_rsp_t i_rsp,
    output node_cfg_pkg::cfg_req_t      o_req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_req = '0;
    end

    // Request held through the taking edge; answer taken one cycle later
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic ok);
        @(posedge i_clk);
        #1;
        o_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge i_clk);
        #1;
        ok = i_rsp.valid;
        rd = i_rsp.rdata;
        // Idle fields flip so stale values are never mistaken for a request
        o_req = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    endtask : access
endmodule : cfg_master

// file: verif/node_config_registers_tb.sv
// Self-checking bench for the node configuration register bank
module node_config_registers_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] SCAN_VAL = 32'h1357_9BDF;  // Arbitrary value
    localparam logic [17:0] FIX_VAL  = 18'h2A5A5;      // Arbitrary value
    localparam logic [13:0] OTP_VAL  = 14'h2C3B;
    localparam node_cfg_pkg::pll_cfg_t PLL_A = '{3'h5, 13'h0123, 7'h1F, 1'b1, 1'b1, 1'b0};

    logic                     i_clk = 1'b0;
    logic                     i_resetn;
    node_cfg_pkg::cfg_req_t   req;
    node_cfg_pkg::cfg_rsp_t   rsp;
    logic                     dbg_event;
    logic [1:0]               dbg_cores;
    logic                     pll_locked;
    logic [15:0]              dest_id;
    logic                     hdr_one;
    logic                     ctl_locked;
    logic [15:0]              node_id;
    node_cfg_pkg::pll_cfg_t   pll;
    logic [15:0]              sw_div;
    logic [15:0]              ref_div;
    logic                     tile_reset;
    logic                     route_local;
    logic [3:0]               route_dir;
    logic [31:0]              rd;
    logic                     ok;
    int                       err_total = 0;
    int                       compares = 0;
    int                       cycles = 0;

    always #2.5 i_clk = ~i_clk;

    cfg_master m (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));

    node_config_registers #(.RESET_CYCLES(4), .SCAN_ID(SCAN_VAL), .USER_FIX(FIX_VAL)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .o_rsp(rsp),
        .i_otp_user(OTP_VAL), .i_dbg_event(dbg_event), .i_dbg_cores(dbg_cores),
        .i_pll_locked(pll_locked), .i_dest_id(dest_id), .o_header_one_byte(hdr_one),
        .o_ctl_locked(ctl_locked), .o_node_id(node_id), .o_pll(pll), .o_switch_div(sw_div),
        .o_ref_div(ref_div), .o_tile_reset(tile_reset), .o_route_local(route_local),
        .o_route_dir(route_dir)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        m.access(1'b1, a, d, rd, ok);
        chk("write answer", 32'h1, {31'h0, ok});
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        m.access(1'b0, a, 32'h0, rd, ok);
        chk("read answer", 32'h1, {31'h0, ok});
        chk($sformatf("register %h", a), exp, rd);
    endtask : rdc

    task automatic t_reset;
        rdc(8'h04, 32'h0);
        rdc(8'h05, 32'h0);
        rdc(8'h07, 32'h0);
        rdc(8'h08, 32'h3);
        rdc(8'h0C, 32'h0);
        rdc(8'h0D, 32'h0);
        rdc(8'h0A, {OTP_VAL, FIX_VAL});
        chk("ref div out", 32'h3, {16'h0, ref_div});
    endtask : t_reset

    task automatic t_regs;
        wr(8'h04, 32'h7FFF_FEFF);
        rdc(8'h04, 32'h1);
        chk("header one byte", 32'h1, {31'h0, hdr_one});
        wr(8'h04, 32'h0);
        cyc(1);
        chk("header two byte", 32'h0, {31'h0, hdr_one});
        wr(8'h05, 32'hFFFF_A5C3);
        wr(8'h07, 32'h1234_BEEF);
        wr(8'h08, 32'hFFFF_0010);
        rdc(8'h05, 32'h0000_A5C3);
        rdc(8'h07, 32'h0000_BEEF);
        rdc(8'h08, 32'h0000_0010);
        chk("node id out", 32'hA5C3, {16'h0, node_id});
        chk("switch div out", 32'hBEEF, {16'h0, sw_div});
        chk("ref div out", 32'h0010, {16'h0, ref_div});
        wr(8'h10, 32'hFFFF_FFFF);
        rdc(8'h10, 32'h3);
        wr(8'h11, 32'hFFFF_FFFE);
        rdc(8'h11, 32'h2);
        wr(8'h09, 32'h0);
        rdc(8'h09, SCAN_VAL);
        rdc(8'h0B, 32'h0);
        for (int c = 2; c > 0; c--) begin
            dbg_cores = 2'(c);
            dbg_event = 1'b1;
            cyc(1);
            dbg_event = 1'b0;
            dbg_cores = ~2'(c);
            rdc(8'h1F, 32'(c));
        end
    endtask : t_regs

    task automatic t_route;
        wr(8'h0C, 32'h7654_3210);
        wr(8'h0D, 32'hFEDC_BA98);
        rdc(8'h0D, 32'hFEDC_BA98);
        for (int k = 0; k < 16; k++) begin
            dest_id = 16'hA5C3 ^ (16'h1 << k) ^ (((16'h1 << k) - 16'h1) & 16'h5555);
            cyc(2);
            chk("route dir", 32'(k), {28'h0, route_dir});
            chk("route far", 32'h0, {31'h0, route_local});
        end
        dest_id = 16'hA5C3;
        cyc(2);
        chk("route local", 32'h1, {31'h0, route_local});
    endtask : t_route

    task automatic t_pll;
        pll_locked = 1'b0;
        wr(8'h06, 32'h3EE1_239F);
        chk("tile reset rise", 32'h1, {31'h0, tile_reset});
        cyc(8);
        chk("tile reset waits lock", 32'h1, {31'h0, tile_reset});
        chk("pll out", {6'h0, PLL_A}, {6'h0, pll});
        pll_locked = 1'b1;
        for (int i = 0; i < 8 && tile_reset !== 1'b0; i++) cyc(1);
        chk("tile reset end", 32'h0, {31'h0, tile_reset});
        rdc(8'h06, 32'h3281_231F);
        pll_locked = 1'b0;
        wr(8'h06, 32'h8000_0101);
        chk("reset skipped", 32'h0, {31'h0, tile_reset});
        cyc(6);
        chk("reset skipped later", 32'h0, {31'h0, tile_reset});
        wr(8'h06, 32'h4000_0000);
        chk("no wait rise", 32'h1, {31'h0, tile_reset});
        for (int i = 0; i < 12 && tile_reset !== 1'b0; i++) cyc(1);
        chk("no wait end", 32'h0, {31'h0, tile_reset});
        chk("no wait out", 32'h1, {31'h0, pll.no_wait});
        pll_locked = 1'b1;
    endtask : t_pll

    task automatic t_lock;
        wr(8'h04, 32'h0000_0100);
        wr(8'h06, 32'h0000_0202);
        chk("locked pll no reset", 32'h0, {31'h0, tile_reset});
        rdc(8'h06, 32'h4000_0000);
        wr(8'h05, 32'h0000_1234);
        rdc(8'h05, 32'h0000_1234);
        wr(8'h04, 32'h8000_0100);
        wr(8'h05, 32'h0000_0FED);
        wr(8'h07, 32'h0000_0001);
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h0);
        rdc(8'h05, 32'h0000_1234);
        rdc(8'h07, 32'h0000_BEEF);
        rdc(8'h0C, 32'h7654_3210);
        rdc(8'h04, 32'h8000_0100);
        chk("ctl lock out", 32'h1, {31'h0, ctl_locked});
        i_resetn = 1'b0;
        cyc(8);
        i_resetn = 1'b1;
        rdc(8'h04, 32'h0);
    endtask : t_lock

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        i_resetn = 1'b0;
        dbg_event = 1'b0;
        dbg_cores = 2'b00;
        pll_locked = 1'b1;
        dest_id = 16'h0;
        cyc(8);
        i_resetn = 1'b1;
        t_reset();
        t_regs();
        t_route();
        t_pll();
        t_lock();
        finish_test();
    end
endmodule : node_config_registers_tb
